// [hdl/comparator_a_control.v]
// Comparator A control and status logic with an AXI4-Lite register slave.
`timescale 1ns/1ns
`include "comp_a_defines.vh"
// Contract
// - Select code 0..3 routes analog input 0..3 to the positive terminal.
// - Connect bit 1 joins the selected pins to the comparator; 0 isolates them.
// - Event flag sets when output meets the chosen mode while enabled.
// - Event flag stays set until software writes it to zero.
// - Interrupt request is gated by bit 6 of the interrupt enable register.
// - Enable clear forces comparator output low and blocks new events.
// - While enabled, the four shared analog pins are held input-only.
// - Output is one when positive input exceeds negative input, else zero.
// - Mode field selects level, edge, toggle and debounced edge or toggle conditions.
// - Debounced modes wait two Timer 1 overflows, then resample against expected value.
module comparator_a_control (
  input  wire        clk,
  input  wire        nrst,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        comp_raw,
  input  wire        timer1_overflow,
  output reg  [3:0]  pos_mux_onehot,
  output reg         input_connect_a,
  output reg  [1:0]  reference_select_a,
  output reg         analog_enable,
  output reg         pins_input_only,
  output reg         comparator_out,
  output wire        comp_irq_request
);
  reg  [7:0] ctrl;
  reg  [7:0] ie_reg;
  reg        comp_meta;
  reg        comp_sync;
  reg        aw_held;
  reg        w_held;
  reg  [3:0] aw_addr;
  reg  [31:0] w_data;
  reg  [3:0] w_strb;
  wire       event_pulse;
  wire       enable_a = ctrl[`ENABLE_BIT];
  wire       do_write = aw_held & w_held & ~s_axi_bvalid;
  wire       ctrl_wr  = do_write & (aw_addr == `CTRL_STATUS_ADDR) & w_strb[0];
  wire       ie_wr    = do_write & (aw_addr == `IRQ_ENABLE_ADDR) & w_strb[0];

  function mapped;
    input [3:0] addr;
    begin
      mapped = (addr == `CTRL_STATUS_ADDR) | (addr == `IRQ_ENABLE_ADDR) | (addr == `COMP_STATE_ADDR);
    end
  endfunction

  // ----------------------------------------------------------------------------
  // Comparator output conditioning
  // ----------------------------------------------------------------------------
  // The analog core already outputs one when plus exceeds minus; it is asynchronous
  // to clk, so it passes two sync flip-flops and the enable gate register before the event logic sees it.
  always @(posedge clk) begin
    if (!nrst) begin
      comp_meta      <= 1'b0;
      comp_sync      <= 1'b0;
      comparator_out <= 1'b0;
    end else begin
      comp_meta      <= comp_raw;
      comp_sync      <= comp_meta;
      comparator_out <= comp_sync & enable_a;
    end
  end

  comp_event_detect u_detect (
    .clk             (clk),
    .nrst            (nrst),
    .enable          (enable_a),
    .mode            (ctrl[`MODE_HI:`MODE_LO]),
    .comp_out        (comparator_out),
    .timer1_overflow (timer1_overflow),
    .event_pulse     (event_pulse)
  );

  // ----------------------------------------------------------------------------
  // Analog switch controls
  // ----------------------------------------------------------------------------
  always @(posedge clk) begin
    if (!nrst) begin
      pos_mux_onehot     <= 4'h0;
      input_connect_a    <= 1'b0;
      analog_enable      <= 1'b0;
      pins_input_only    <= 1'b0;
      reference_select_a <= 2'h0;
    end else begin
      // Switches stay open unless connect is set, so a mux change done with
      // connect cleared never glitches the comparator input.
      pos_mux_onehot  <= ctrl[`CONNECT_BIT] ? (4'h1 << ctrl[`SEL_HI:`SEL_LO]) : 4'h0;
      input_connect_a <= ctrl[`CONNECT_BIT];
      analog_enable   <= enable_a;
      pins_input_only <= enable_a;
      reference_select_a <= 2'h0;
    end
  end

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  always @(posedge clk) begin
    if (!nrst) begin
      ctrl   <= `CTRL_RESET;
      ie_reg <= `IE_RESET;
    end else begin
      if (ctrl_wr) begin
        ctrl <= w_data[7:0];
        ctrl[`FLAG_BIT] <= (w_data[`FLAG_BIT] & ctrl[`FLAG_BIT]) | event_pulse;
      end else if (event_pulse) begin
        ctrl[`FLAG_BIT] <= 1'b1;
      end
      if (ie_wr)
        ie_reg <= w_data[7:0];
    end
  end

  assign comp_irq_request = ctrl[`FLAG_BIT] & ie_reg[`IE_COMP_BIT];

  // ----------------------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------------------
  assign s_axi_awready = ~aw_held;
  assign s_axi_wready  = ~w_held;

  always @(posedge clk) begin
    if (!nrst) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 4'h0;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge clk) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        case (s_axi_araddr)
          `CTRL_STATUS_ADDR: s_axi_rdata <= {24'h000000, ctrl};
          `IRQ_ENABLE_ADDR:  s_axi_rdata <= {24'h000000, ie_reg};
          `COMP_STATE_ADDR:  s_axi_rdata <= {30'h00000000, comp_irq_request, comparator_out};
          default:           s_axi_rdata <= 32'h00000000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // comparator_a_control

// [common/comp_a_defines.vh]
// Offsets, field positions, reset values and encodings of the comparator A control block.
`ifndef COMP_A_DEFINES_VH
`define COMP_A_DEFINES_VH
// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define CTRL_STATUS_ADDR  4'h0
`define IRQ_ENABLE_ADDR   4'h4
`define COMP_STATE_ADDR   4'h8
// ----------------------------------------------------------------------------
// Control and status fields, interrupt enable field
// ----------------------------------------------------------------------------
`define SEL_HI            7
`define SEL_LO            6
`define CONNECT_BIT       5
`define FLAG_BIT          4
`define ENABLE_BIT        3
`define MODE_HI           2
`define MODE_LO           0
`define CTRL_RESET        8'h00
`define IE_COMP_BIT       6
`define IE_RESET          8'h00
// ----------------------------------------------------------------------------
// Interrupt mode encodings
// ----------------------------------------------------------------------------
`define MODE_LOW_LEVEL    3'h0
`define MODE_POS_EDGE     3'h1
`define MODE_TOGGLE_DB    3'h2
`define MODE_POS_EDGE_DB  3'h3
`define MODE_NEG_EDGE     3'h4
`define MODE_TOGGLE       3'h5
`define MODE_NEG_EDGE_DB  3'h6
`define MODE_HIGH_LEVEL   3'h7
`define DB_OVERFLOWS      2'h2
// ----------------------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------------------
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`endif

// [hdl/comp_event_detect.v]
// Event detector of comparator A: level, edge, toggle and debounced modes.
`timescale 1ns/1ns
`include "comp_a_defines.vh"
module comp_event_detect (
  input  wire       clk,
  input  wire       nrst,
  input  wire       enable,
  input  wire [2:0] mode,
  input  wire       comp_out,
  input  wire       timer1_overflow,
  output reg        event_pulse
);
  localparam IDLE = 1'b0;
  localparam WAIT = 1'b1;

  reg       prev_out;
  reg       state;
  reg       expect_val;
  reg [1:0] ovf_count;
  wire      rise = comp_out & ~prev_out;
  wire      fall = ~comp_out & prev_out;
  wire      debounce = (mode == `MODE_TOGGLE_DB) | (mode == `MODE_POS_EDGE_DB) | (mode == `MODE_NEG_EDGE_DB);
  reg       hit;
  reg       trigger;

  // ----------------------------------------------------------------------------
  // Condition decode
  // ----------------------------------------------------------------------------
  always @* begin
    hit = 1'b0;
    trigger = 1'b0;
    case (mode)
      `MODE_LOW_LEVEL:   hit = ~comp_out;
      `MODE_POS_EDGE:    hit = rise;
      `MODE_NEG_EDGE:    hit = fall;
      `MODE_TOGGLE:      hit = rise | fall;
      `MODE_HIGH_LEVEL:  hit = comp_out;
      `MODE_TOGGLE_DB:   trigger = rise | fall;
      `MODE_POS_EDGE_DB: trigger = rise;
      `MODE_NEG_EDGE_DB: trigger = fall;
      default:           hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------------
  // Debounce sequencer
  // ----------------------------------------------------------------------------
  // Timer 1 runs free, so two overflows guarantee at least one full period.
  always @(posedge clk) begin
    if (!nrst) begin
      prev_out    <= 1'b0;
      state       <= IDLE;
      expect_val  <= 1'b0;
      ovf_count   <= 2'h0;
      event_pulse <= 1'b0;
    end else begin
      prev_out    <= comp_out;
      event_pulse <= 1'b0;
      if (!enable || !debounce) begin
        state       <= IDLE;
        ovf_count   <= 2'h0;
        event_pulse <= enable & hit;
      end else begin
        case (state)
          IDLE: begin
            if (trigger) begin
              state      <= WAIT;
              expect_val <= comp_out;
              ovf_count  <= 2'h0;
            end
          end
          WAIT: begin
            if (timer1_overflow) begin
              if (ovf_count + 2'h1 == `DB_OVERFLOWS) begin
                state       <= IDLE;
                event_pulse <= (comp_out == expect_val);
              end else begin
                ovf_count <= ovf_count + 2'h1;
              end
            end
          end
          default: state <= IDLE;
        endcase
      end
    end
  end
endmodule // comp_event_detect

// [dv/comp_a_chk.sv]
// Port-level assertions for comparator A control.
`timescale 1ns/1ns
module comp_a_chk (
  input logic       clk,
  input logic       nrst,
  input logic       s_axi_arvalid,
  input logic       s_axi_arready,
  input logic       s_axi_rvalid,
  input logic       s_axi_bvalid,
  input logic       comp_raw,
  input logic [3:0] pos_mux_onehot,
  input logic       input_connect_a,
  input logic       analog_enable,
  input logic       pins_input_only,
  input logic       comparator_out,
  input logic       comp_irq_request
);
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_sel; input_connect_a |-> $onehot(pos_mux_onehot); endproperty
  a_sel: assert property (p_sel) else $error("select not one-hot");
  property p_open; !input_connect_a |-> pos_mux_onehot == 4'h0; endproperty
  a_open: assert property (p_open) else $error("switch closed while disconnected");
  property p_set; $rose(comp_irq_request) |-> s_axi_bvalid || $past(analog_enable); endproperty
  a_set: assert property (p_set) else $error("request rose while disabled");
  property p_hold; $fell(comp_irq_request) |-> s_axi_bvalid; endproperty
  a_hold: assert property (p_hold) else $error("request fell without a write");
  property p_low; !analog_enable |-> !comparator_out; endproperty
  a_low: assert property (p_low) else $error("output high while disabled");
  property p_pins; pins_input_only == analog_enable; endproperty
  a_pins: assert property (p_pins) else $error("pin mode not tied to enable");
  // The output is three edges behind the raw result: two sync stages and the gate register.
  property p_out; analog_enable && $past(analog_enable, 4) |-> comparator_out == $past(comp_raw, 3); endproperty
  a_out: assert property (p_out) else $error("output does not follow comparator");
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
endmodule // comp_a_chk
bind comparator_a_control comp_a_chk u_chk (.clk, .nrst, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid,
  .comp_raw, .pos_mux_onehot, .input_connect_a, .analog_enable, .pins_input_only, .comparator_out, .comp_irq_request);

// [dv/analog_core.sv]
// Behavioural analog comparator core with a free-running Timer 1 overflow source.
`timescale 1ns/1ns
module analog_core (
  input  logic       clk,
  input  logic [3:0] pos_mux_onehot,
  input  logic       analog_enable,
  input  logic [3:0] ain_above,
  output logic       comp_raw,
  output logic       timer1_overflow
);
  logic [1:0] tick;
  initial begin
    tick = 2'h0;
    comp_raw = 1'b0;
    timer1_overflow = 1'b0;
  end
  // --------------
  // Analog result
  // --------------
  always @(posedge clk) begin
    tick <= tick + 2'h1;
    timer1_overflow <= (tick == 2'h3);
    // An unpowered or open input has no settled answer, so it chatters rather than sit at a kind level.
    if (!analog_enable || pos_mux_onehot == 4'h0) begin
      comp_raw <= ~comp_raw;
    end else begin
      comp_raw <= |(pos_mux_onehot & ain_above);
    end
  end
endmodule // analog_core

// [dv/testbench.sv]
// Self-checking bench for comparator A control.
`timescale 1ns/1ns
`include "comp_a_defines.vh"
module testbench;
  logic        clk = 1'b0, nrst = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF, ain_above = 4'h0, pos_mux_onehot;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp, reference_select_a;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, comp_raw, timer1_overflow;
  logic        input_connect_a, analog_enable, pins_input_only, comparator_out, comp_irq_request;
  logic [7:0]  ctrl = 8'h00;
  int          failures = 0, check_count = 0;
  comparator_a_control u_dut (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .comp_raw, .timer1_overflow,
    .pos_mux_onehot, .input_connect_a, .reference_select_a, .analog_enable, .pins_input_only, .comparator_out,
    .comp_irq_request);
  analog_core u_core (.clk, .pos_mux_onehot, .analog_enable, .ain_above, .comp_raw, .timer1_overflow);
  always #4 clk = ~clk;
  // ------------
  // Bus helpers
  // ------------
  task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask
  // Handshakes are judged on the values that stand before an edge, never on what that edge launches.
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
    logic [31:0] x;
    logic        aw_ok, w_ok, b_ok;
    logic [1:0]  rsp;
    x = $urandom();
    s_axi_awaddr <= a;
    s_axi_wdata <= {x[31:8], d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(negedge clk);
      aw_ok = s_axi_awvalid & s_axi_awready;
      w_ok = s_axi_wvalid & s_axi_wready;
      b_ok = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge clk);
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
    end while (!b_ok);
    chk("bresp", rsp, r);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] e, input logic [1:0] r);
    logic        ar_ok, r_ok;
    logic [31:0] dat;
    logic [1:0]  rsp;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge clk);
      ar_ok = s_axi_arvalid & s_axi_arready;
      r_ok = s_axi_rvalid;
      dat = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge clk);
      if (ar_ok) s_axi_arvalid <= 1'b0;
    end while (!r_ok);
    chk("rdata", dat, e);
    chk("rresp", rsp, r);
  endtask
  // Changing the select first opens the switch, then moves it, then closes it again.
  task automatic setc(input logic [7:0] v);
    if (v[7:6] != ctrl[7:6]) begin
      wr(`CTRL_STATUS_ADDR, ctrl & 8'hDF, `RESP_OKAY);
      wr(`CTRL_STATUS_ADDR, v & 8'hDF, `RESP_OKAY);
    end
    ctrl = v;
    wr(`CTRL_STATUS_ADDR, v, `RESP_OKAY);
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    finish_test();
  end
  // ---------
  // Scenarios
  // ---------
  initial begin
    void'($urandom(32'hECD2A348));
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rdchk(`CTRL_STATUS_ADDR, 32'h0, `RESP_OKAY);
    rdchk(`IRQ_ENABLE_ADDR, 32'h0, `RESP_OKAY);
    rdchk(4'hC, 32'h0, `RESP_SLVERR);
    wr(4'hC, 8'hFF, `RESP_SLVERR);
    chk("ref", reference_select_a, 2'h0);
    for (int i = 0; i < 4; i++) begin
      ain_above <= 4'($urandom());
      setc({i[1:0], 6'b101000});
      repeat (8) @(posedge clk);
      chk("mux", pos_mux_onehot, 4'h1 << i);
      chk("conn", input_connect_a, 1'b1);
      chk("out", comparator_out, ain_above[i]);
      chk("pins", pins_input_only, 1'b1);
      chk("enable", analog_enable, 1'b1);
    end
    setc(ctrl & 8'hDF);
    repeat (4) @(posedge clk);
    chk("mux", pos_mux_onehot, 4'h0);
    chk("conn", input_connect_a, 1'b0);
    for (int i = 0; i < 8; i++) begin
      ain_above <= 4'h0;
      setc({5'b00101, i[2:0]});
      repeat (40) @(posedge clk);
      setc(ctrl);
      ain_above <= 4'hF;
      repeat (40) @(posedge clk);
      rdchk(`CTRL_STATUS_ADDR, {24'h0, ctrl | ((i == `MODE_NEG_EDGE || i == `MODE_NEG_EDGE_DB) ? 8'h00 : 8'h10)},
        `RESP_OKAY);
    end
    ain_above <= 4'h0;
    repeat (20) @(posedge clk);
    rdchk(`CTRL_STATUS_ADDR, {24'h0, ctrl | 8'h10}, `RESP_OKAY);
    rdchk(`COMP_STATE_ADDR, 32'h0, `RESP_OKAY);
    wr(`IRQ_ENABLE_ADDR, 8'h40, `RESP_OKAY);
    rdchk(`COMP_STATE_ADDR, 32'h2, `RESP_OKAY);
    wr(`IRQ_ENABLE_ADDR, 8'hBF, `RESP_OKAY);
    chk("irq", comp_irq_request, 1'b0);
    wr(`IRQ_ENABLE_ADDR, 8'h40, `RESP_OKAY);
    chk("irq", comp_irq_request, 1'b1);
    setc(ctrl);
    chk("irq", comp_irq_request, 1'b0);
    ain_above <= 4'hF;
    setc(8'h27);
    repeat (20) @(posedge clk);
    chk("out", comparator_out, 1'b0);
    chk("enable", analog_enable, 1'b0);
    chk("pins", pins_input_only, 1'b0);
    rdchk(`CTRL_STATUS_ADDR, 32'h27, `RESP_OKAY);
    finish_test();
  end
endmodule // testbench
